// ===== rtl/pllcrb_pkg.sv
// Package for the clock synthesizer control register bank.
// Assumes a single 10 MHz clock; serial port pins are sampled in that domain.
package pllcrb_pkg;

	// ==========================================
	// Register offsets on the serial port
	localparam int         ADDR_W       = 7;
	localparam logic [6:0] ADDR_BYPASS  = 7'h17;
	localparam logic [6:0] ADDR_OSC     = 7'h18;
	localparam logic [6:0] ADDR_TUNING  = 7'h1c;
	localparam logic [6:0] ADDR_OFFSET  = 7'h1d;
	localparam logic [6:0] ADDR_PUMP2   = 7'h1e;
	localparam int         REG_COUNT    = 5;
	localparam logic [2:0] REG_NONE     = 3'h5;
	localparam logic [REG_COUNT-1:0][6:0] REG_ADDR =
		{ADDR_PUMP2, ADDR_OFFSET, ADDR_TUNING, ADDR_OSC, ADDR_BYPASS};

	// ==========================================
	// Register indices in the bank
	localparam int IDX_BYPASS = 0;
	localparam int IDX_OSC    = 1;
	localparam int IDX_TUNING = 2;
	localparam int IDX_OFFSET = 3;
	localparam int IDX_PUMP2  = 4;

	// ==========================================
	// Field positions
	localparam int BYPASS_BIT = 0;
	localparam int OSC_BIT    = 0;
	localparam int POL_BIT    = 7;
	localparam int FORCE_BIT  = 6;
	localparam int OFS_EN_BIT = 5;
	localparam int CODE_LSB   = 0;
	localparam int CODE_W     = 5;

	// ==========================================
	// Reset values and writable-bit masks
	localparam logic [7:0] RST_BYPASS  = 8'h00;
	localparam logic [7:0] RST_OSC     = 8'h00;
	localparam logic [7:0] RST_TUNING  = 8'h4f;
	localparam logic [7:0] RST_OFFSET  = 8'h00;
	localparam logic [7:0] RST_PUMP2   = 8'h06;
	localparam logic [7:0] MASK_BYPASS = 8'h01;
	localparam logic [7:0] MASK_OSC    = 8'h01;
	localparam logic [7:0] MASK_TUNING = 8'hdf;
	localparam logic [7:0] MASK_OFFSET = 8'h3f;
	localparam logic [7:0] MASK_PUMP2  = 8'h1f;
	localparam logic [REG_COUNT-1:0][7:0] REG_RST =
		{RST_PUMP2, RST_OFFSET, RST_TUNING, RST_OSC, RST_BYPASS};
	localparam logic [REG_COUNT-1:0][7:0] REG_MASK =
		{MASK_PUMP2, MASK_OFFSET, MASK_TUNING, MASK_OSC, MASK_BYPASS};

	// ==========================================
	// Analog scaling steps and second loop predivider codes
	localparam logic [10:0] PUMP1_STEP_UA  = 11'h032;
	localparam logic [12:0] PUMP2_STEP_UA  = 13'h0c8;
	localparam logic [8:0]  OFS_STEP_DDEG  = 9'h009;
	localparam logic [5:0]  PREDIV_BYPASS  = 6'h00;
	localparam logic [5:0]  PREDIV_UNITY   = 6'h01;

	// ==========================================
	// Serial frame
	localparam logic [3:0] BIT_LAST_HEAD = 4'h7;
	localparam logic [3:0] BIT_FIRST_TX  = 4'h9;
	localparam logic [3:0] BIT_LAST_BODY = 4'hf;

	typedef enum logic [1:0] {
		PLLCRB_IDLE = 2'b00,
		PLLCRB_HEAD = 2'b01,
		PLLCRB_BODY = 2'b11,
		PLLCRB_DONE = 2'b10
	} pllcrb_frame_t;

endpackage

// ===== rtl/pllcrb_spi_engine.sv
// Serial frame engine: R/W bit, 7-bit address, 8 data bits, MSB first.
// Assumes synchronised pins; data sampled on rising, shifted out on falling edge.
`timescale 1ns/100ps
module pllcrb_spi_engine
(
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic       sclk_in,
	input  wire logic       cs_n_in,
	input  wire logic       mosi_in,
	input  wire logic [7:0] rd_data_in,
	output logic      [6:0] rd_addr_out,
	output logic            wr_strobe_out,
	output logic      [6:0] wr_addr_out,
	output logic      [7:0] wr_data_out,
	output logic            miso_out,
	output logic            miso_oe_out
);
	typedef struct packed {
		pllcrb_pkg::pllcrb_frame_t frame;
		logic       sclk_q;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       rnw;
		logic [6:0] addr;
		logic       load;
		logic [7:0] tx;
		logic       wr;
		logic [7:0] wdata;
	} pllcrb_eng_t;

	localparam pllcrb_eng_t ENG_RST = '{pllcrb_pkg::PLLCRB_IDLE, 1'b0, 4'h0, 8'h00,
		1'b0, 7'h00, 1'b0, 8'h00, 1'b0, 8'h00};

	pllcrb_eng_t st;
	pllcrb_eng_t next_st;
	logic        rise;
	logic        fall;

	assign rise = sclk_in & ~st.sclk_q;
	assign fall = ~sclk_in & st.sclk_q;

	// ==========================================
	// Frame sequencing
	always_comb
	begin
		next_st = st;
		next_st.sclk_q = sclk_in;
		next_st.wr = 1'b0;
		if (st.load)
		begin
			next_st.tx = rd_data_in;
			next_st.load = 1'b0;
		end
		unique case (st.frame)
			pllcrb_pkg::PLLCRB_IDLE:
			begin
				next_st.cnt = 4'h0;
				if (!cs_n_in)
					next_st.frame = pllcrb_pkg::PLLCRB_HEAD;
			end
			pllcrb_pkg::PLLCRB_HEAD:
			begin
				if (rise)
				begin
					next_st.sh = {st.sh[6:0], mosi_in};
					next_st.cnt = st.cnt + 4'h1;
					if (st.cnt == pllcrb_pkg::BIT_LAST_HEAD)
					begin
						next_st.rnw = st.sh[6];
						next_st.addr = {st.sh[5:0], mosi_in};
						next_st.load = st.sh[6];
						next_st.tx = 8'h00;
						next_st.frame = pllcrb_pkg::PLLCRB_BODY;
					end
				end
			end
			pllcrb_pkg::PLLCRB_BODY:
			begin
				if (rise)
				begin
					next_st.sh = {st.sh[6:0], mosi_in};
					next_st.cnt = st.cnt + 4'h1;
					if (st.cnt == pllcrb_pkg::BIT_LAST_BODY)
					begin
						next_st.wr = ~st.rnw;
						next_st.wdata = {st.sh[6:0], mosi_in};
						next_st.frame = pllcrb_pkg::PLLCRB_DONE;
					end
				end
				else if (fall && st.cnt >= pllcrb_pkg::BIT_FIRST_TX)
					next_st.tx = {st.tx[6:0], 1'b0};
			end
			pllcrb_pkg::PLLCRB_DONE:
			begin
				next_st.tx = 8'h00;
			end
		endcase
		if (cs_n_in)
			next_st.frame = pllcrb_pkg::PLLCRB_IDLE;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			st <= ENG_RST;
		else if (ce_in)
			st <= next_st;
	end

	assign rd_addr_out   = st.addr;
	assign wr_strobe_out = st.wr;
	assign wr_addr_out   = st.addr;
	assign wr_data_out   = st.wdata;
	assign miso_out      = st.tx[7];
	assign miso_oe_out   = (st.frame != pllcrb_pkg::PLLCRB_IDLE);

endmodule // pllcrb_spi_engine

// ===== rtl/pllcrb_bank.sv
// Control register bank of a two-stage clock synthesizer, on a serial port.
// Assumes serial pins asynchronous to mclk_in, with sclk at most 1 MHz.
`timescale 1ns/100ps
module pllcrb_bank
#(
	parameter int SYNC_STAGES = 2
)
(
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	input  wire logic        spi_sclk_in,
	input  wire logic        spi_cs_n_in,
	input  wire logic        spi_mosi_in,
	output logic             spi_miso_out,
	output logic             spi_miso_oe_out,
	input  wire logic        input_doubler_select_in,
	input  wire logic [5:0]  second_loop_predivider_in,
	output logic             first_loop_bypass_out,
	output logic             first_loop_enable_out,
	output logic             oscillator_choice_out,
	output logic             tuning_polarity_out,
	output logic             force_mid_tuning_out,
	output logic             loop_filter_tuning_pin_mid_out,
	output logic      [4:0]  first_pump_current_code_out,
	output logic      [10:0] first_pump_current_ua_out,
	output logic             phase_offset_enable_out,
	output logic      [4:0]  phase_offset_code_out,
	output logic      [4:0]  applied_offset_code_out,
	output logic      [8:0]  applied_offset_decideg_out,
	output logic      [4:0]  second_pump_current_code_out,
	output logic      [12:0] second_pump_current_ua_out,
	output logic             second_loop_doubled_out,
	output logic      [5:0]  second_loop_divide_out
);

	// ==========================================
	// Parameter check
	generate
		if (SYNC_STAGES < 2)
		begin : g_bad_sync
			$error("SYNC_STAGES must be at least 2");
		end
	endgenerate

	// ==========================================
	// State
	typedef struct packed {
		logic        bypass;
		logic        first_en;
		logic        osc;
		logic        pol;
		logic        force_mid;
		logic        pin_mid;
		logic [4:0]  cp1;
		logic [10:0] cp1_ua;
		logic        ofs_en;
		logic [4:0]  ofs;
		logic [4:0]  ofs_applied;
		logic [8:0]  ofs_ddeg;
		logic [4:0]  cp2;
		logic [12:0] cp2_ua;
		logic        doubled;
		logic [5:0]  divide;
	} pllcrb_drive_t;

	typedef struct packed {
		logic [SYNC_STAGES-1:0][2:0]             sync;
		logic [pllcrb_pkg::REG_COUNT-1:0][7:0]   regs;
		pllcrb_drive_t                           drv;
	} pllcrb_state_t;

	localparam pllcrb_drive_t DRV_RST = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1,
		5'h0f, 11'h320, 1'b0, 5'h00, 5'h00, 9'h000, 5'h06, 13'h0578, 1'b0, 6'h01};
	localparam pllcrb_state_t ST_RST = '{'0, pllcrb_pkg::REG_RST, DRV_RST};

	pllcrb_state_t st;
	pllcrb_state_t next_st;

	logic [2:0] pins_sync;
	logic       wr_strobe;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;

	// ==========================================
	// Address decode, shared by read and write
	function automatic logic [2:0] reg_index(input logic [6:0] addr);
		logic [2:0] idx;
		idx = pllcrb_pkg::REG_NONE;
		for (int i = 0; i < pllcrb_pkg::REG_COUNT; i++)
		begin
			if (addr == pllcrb_pkg::REG_ADDR[i])
				idx = 3'(i);
		end
		return idx;
	endfunction

	assign wr_idx = reg_index(wr_addr);
	assign rd_idx = reg_index(rd_addr);

	// Unmapped reads return zero
	assign rd_data = (rd_idx == pllcrb_pkg::REG_NONE) ? 8'h00 : st.regs[rd_idx];

	// Last synchroniser stage only
	assign pins_sync = st.sync[SYNC_STAGES-1];

	// ==========================================
	// Serial frame engine
	pllcrb_spi_engine u_engine
	(
		.mclk_in       (mclk_in),
		.rst_n_in      (rst_n_in),
		.ce_in         (ce_in),
		.sclk_in       (pins_sync[0]),
		.cs_n_in       (pins_sync[1]),
		.mosi_in       (pins_sync[2]),
		.rd_data_in    (rd_data),
		.rd_addr_out   (rd_addr),
		.wr_strobe_out (wr_strobe),
		.wr_addr_out   (wr_addr),
		.wr_data_out   (wr_data),
		.miso_out      (spi_miso_out),
		.miso_oe_out   (spi_miso_oe_out)
	);

	// ==========================================
	// Next state
	always_comb
	begin
		next_st = st;

		// Pin synchronisers
		next_st.sync[0] = {spi_mosi_in, spi_cs_n_in, spi_sclk_in};
		for (int s = 1; s < SYNC_STAGES; s++)
			next_st.sync[s] = st.sync[s-1];

		// Register writes, reserved bits dropped
		if (wr_strobe && wr_idx != pllcrb_pkg::REG_NONE)
			next_st.regs[wr_idx] = wr_data & pllcrb_pkg::REG_MASK[wr_idx];

		// First loop bypass
		next_st.drv.bypass = next_st.regs[pllcrb_pkg::IDX_BYPASS][pllcrb_pkg::BYPASS_BIT];
		next_st.drv.first_en = ~next_st.drv.bypass;

		// Oscillator choice
		next_st.drv.osc = next_st.regs[pllcrb_pkg::IDX_OSC][pllcrb_pkg::OSC_BIT];

		// Tuning control
		next_st.drv.pol = next_st.regs[pllcrb_pkg::IDX_TUNING][pllcrb_pkg::POL_BIT];
		next_st.drv.force_mid = next_st.regs[pllcrb_pkg::IDX_TUNING][pllcrb_pkg::FORCE_BIT];
		next_st.drv.pin_mid = next_st.drv.force_mid;

		// First pump current
		next_st.drv.cp1 =
			next_st.regs[pllcrb_pkg::IDX_TUNING][pllcrb_pkg::CODE_LSB +: pllcrb_pkg::CODE_W];
		next_st.drv.cp1_ua =
			11'((11'(next_st.drv.cp1) + 11'h001) * pllcrb_pkg::PUMP1_STEP_UA);

		// Phase offset
		next_st.drv.ofs_en = next_st.regs[pllcrb_pkg::IDX_OFFSET][pllcrb_pkg::OFS_EN_BIT];
		next_st.drv.ofs =
			next_st.regs[pllcrb_pkg::IDX_OFFSET][pllcrb_pkg::CODE_LSB +: pllcrb_pkg::CODE_W];
		next_st.drv.ofs_applied = next_st.drv.ofs_en ? next_st.drv.ofs : 5'h00;
		next_st.drv.ofs_ddeg =
			9'(9'(next_st.drv.ofs_applied) * pllcrb_pkg::OFS_STEP_DDEG);

		// Second pump current
		next_st.drv.cp2 =
			next_st.regs[pllcrb_pkg::IDX_PUMP2][pllcrb_pkg::CODE_LSB +: pllcrb_pkg::CODE_W];
		next_st.drv.cp2_ua =
			13'((13'(next_st.drv.cp2) + 13'h0001) * pllcrb_pkg::PUMP2_STEP_UA);

		// Second loop input path
		next_st.drv.doubled = input_doubler_select_in;
		if (input_doubler_select_in || second_loop_predivider_in == pllcrb_pkg::PREDIV_BYPASS)
			next_st.drv.divide = pllcrb_pkg::PREDIV_UNITY;
		else
			next_st.drv.divide = second_loop_predivider_in;
	end

	// ==========================================
	// State register
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			st <= ST_RST;
		else if (ce_in)
			st <= next_st;
	end

	// ==========================================
	// Outputs
	assign first_loop_bypass_out          = st.drv.bypass;
	assign first_loop_enable_out          = st.drv.first_en;
	assign oscillator_choice_out          = st.drv.osc;
	assign tuning_polarity_out            = st.drv.pol;
	assign force_mid_tuning_out           = st.drv.force_mid;
	assign loop_filter_tuning_pin_mid_out = st.drv.pin_mid;
	assign first_pump_current_code_out    = st.drv.cp1;
	assign first_pump_current_ua_out      = st.drv.cp1_ua;
	assign phase_offset_enable_out        = st.drv.ofs_en;
	assign phase_offset_code_out          = st.drv.ofs;
	assign applied_offset_code_out        = st.drv.ofs_applied;
	assign applied_offset_decideg_out     = st.drv.ofs_ddeg;
	assign second_pump_current_code_out   = st.drv.cp2;
	assign second_pump_current_ua_out     = st.drv.cp2_ua;
	assign second_loop_doubled_out        = st.drv.doubled;
	assign second_loop_divide_out         = st.drv.divide;

endmodule // pllcrb_bank

// ===== test/pllcrb_bank_checker.sv
// Concurrent checks on the ports of the synthesizer control register bank.
// Assumes one 10 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps
module pllcrb_bank_checker
(
	input wire logic        mclk_in,
	input wire logic        rst_n_in,
	input wire logic        ce_in,
	input wire logic        input_doubler_select_in,
	input wire logic [5:0]  second_loop_predivider_in,
	input wire logic        first_loop_bypass_out,
	input wire logic        first_loop_enable_out,
	input wire logic        oscillator_choice_out,
	input wire logic        tuning_polarity_out,
	input wire logic        force_mid_tuning_out,
	input wire logic        loop_filter_tuning_pin_mid_out,
	input wire logic [4:0]  first_pump_current_code_out,
	input wire logic [10:0] first_pump_current_ua_out,
	input wire logic        phase_offset_enable_out,
	input wire logic [4:0]  phase_offset_code_out,
	input wire logic [4:0]  applied_offset_code_out,
	input wire logic [8:0]  applied_offset_decideg_out,
	input wire logic [4:0]  second_pump_current_code_out,
	input wire logic [12:0] second_pump_current_ua_out,
	input wire logic        second_loop_doubled_out,
	input wire logic [5:0]  second_loop_divide_out
);
	// ==========================================
	// Assertions
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_bypass_enable_pair: assert property (first_loop_enable_out == !first_loop_bypass_out)
		else $error("loop enable not inverse of bypass");
	a_pin_follows_force: assert property (loop_filter_tuning_pin_mid_out == force_mid_tuning_out)
		else $error("tuning pin does not follow force bit");
	a_pump1_scale: assert property (first_pump_current_ua_out == 11'h032 * (11'(first_pump_current_code_out) + 11'h001))
		else $error("first pump current scale wrong");
	a_pump2_scale: assert property (second_pump_current_ua_out == 13'h0c8 * (13'(second_pump_current_code_out) + 13'h001))
		else $error("second pump current scale wrong");
	a_offset_gate: assert property (applied_offset_code_out == (phase_offset_enable_out ? phase_offset_code_out : 5'h00))
		else $error("applied offset not gated by enable");
	a_offset_scale: assert property (applied_offset_decideg_out == 9'h009 * 9'(applied_offset_code_out))
		else $error("offset scale wrong");
	a_reset_force_set: assert property ($rose(rst_n_in) |-> force_mid_tuning_out && loop_filter_tuning_pin_mid_out)
		else $error("force bit not set out of reset");
	a_reset_field_values: assert property ($rose(rst_n_in) |-> {oscillator_choice_out, tuning_polarity_out,
		phase_offset_code_out, first_pump_current_code_out, second_pump_current_code_out}
		== {1'b0, 1'b0, 5'h00, 5'h0f, 5'h06})
		else $error("field reset values wrong");
	a_second_loop_input: assert property ($past(rst_n_in) && $past(ce_in) |->
		second_loop_doubled_out == $past(input_doubler_select_in)
		&& second_loop_divide_out == (($past(input_doubler_select_in) || $past(second_loop_predivider_in) == 6'h00)
		? 6'h01 : $past(second_loop_predivider_in)))
		else $error("second loop input selection wrong");
endmodule // pllcrb_bank_checker

bind pllcrb_bank pllcrb_bank_checker u_checker (.*);

// ===== test/pllcrb_bank_bench.sv
// Self-checking bench for the control register bank, driving the serial port.
// Assumes the checker is bound separately; clock enable held high except during t_enable_and_reset.
`timescale 1ns/100ps
module pllcrb_bank_bench;
	logic mclk_in, rst_n_in, ce_in, spi_sclk_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, spi_miso_oe_out;
	logic input_doubler_select_in, byp, ena, osc, pol, frc, pin, ofs_en, dbl;
	logic [5:0] second_loop_predivider_in, div;
	logic [4:0] cp1, ofs, appl, cp2;
	logic [10:0] cp1_ua;
	logic [8:0] ddeg;
	logic [12:0] cp2_ua;
	logic [7:0] q;
	int error_cnt, cmp_count;

	`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
		$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

	pllcrb_bank dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .spi_sclk_in(spi_sclk_in),
		.spi_cs_n_in(spi_cs_n_in), .spi_mosi_in(spi_mosi_in), .spi_miso_out(spi_miso_out),
		.spi_miso_oe_out(spi_miso_oe_out), .input_doubler_select_in(input_doubler_select_in),
		.second_loop_predivider_in(second_loop_predivider_in), .first_loop_bypass_out(byp),
		.first_loop_enable_out(ena), .oscillator_choice_out(osc), .tuning_polarity_out(pol),
		.force_mid_tuning_out(frc), .loop_filter_tuning_pin_mid_out(pin),
		.first_pump_current_code_out(cp1), .first_pump_current_ua_out(cp1_ua),
		.phase_offset_enable_out(ofs_en), .phase_offset_code_out(ofs), .applied_offset_code_out(appl),
		.applied_offset_decideg_out(ddeg), .second_pump_current_code_out(cp2),
		.second_pump_current_ua_out(cp2_ua), .second_loop_doubled_out(dbl), .second_loop_divide_out(div));

	// ==========================================
	// Clock, time-zero values, watchdog
	initial mclk_in = 1'b0;
	always #50 mclk_in = ~mclk_in;

	initial
	begin
		#3000000;
		error_cnt++;
		stop_test();
	end

	task automatic wt(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// One 16-bit mode 0 frame, each sclk phase five clocks long
	task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d, output logic [7:0] rd);
		logic [15:0] f;
		f = {rw, a, d};
		rd = 8'h00;
		spi_cs_n_in = 1'b0;
		wt(5);
		for (int i = 15; i >= 0; i--)
		begin
			spi_mosi_in = f[i];
			wt(5);
			if (i < 8)
				rd = {rd[6:0], spi_miso_out};
			spi_sclk_in = 1'b1;
			wt(5);
			spi_sclk_in = 1'b0;
		end
		wt(5);
		spi_cs_n_in = 1'b1;
		spi_mosi_in = 1'b0;
		wt(8);
	endtask

	task automatic t_reset_values();
		logic [6:0] ad [5] = '{7'h17, 7'h18, 7'h1c, 7'h1d, 7'h1e};
		logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h4f, 8'h00, 8'h06};
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'b1, ad[i], 8'h00, q);
			`CHK("reset readback", rv[i], q)
		end
		`CHK("enable", 1'b1, ena)
		`CHK("force", 1'b1, frc)
		`CHK("pump1 ua", 11'h320, cp1_ua)
		`CHK("pump2 ua", 13'h578, cp2_ua)
		$display("test reset values done");
	endtask

	task automatic t_all_ones();
		logic [6:0] ad [5] = '{7'h17, 7'h18, 7'h1c, 7'h1d, 7'h1e};
		logic [7:0] mk [5] = '{8'h01, 8'h01, 8'hdf, 8'h3f, 8'h1f};
		for (int i = 0; i < 5; i++)
		begin
			xfer(1'b0, ad[i], 8'hff, q);
			xfer(1'b1, ad[i], 8'h00, q);
			`CHK("masked readback", mk[i], q)
		end
		`CHK("bypass", 2'b10, {byp, ena})
		`CHK("osc", 1'b1, osc)
		`CHK("polarity", 1'b1, pol)
		`CHK("pin mid", 1'b1, pin)
		`CHK("pump1 ua", 11'h640, cp1_ua)
		`CHK("offset ddeg", 9'h117, ddeg)
		`CHK("pump2 ua", 13'h1900, cp2_ua)
		$display("test all ones done");
	endtask

	task automatic t_clear_and_offset();
		xfer(1'b0, 7'h1c, 8'h0f, q);
		`CHK("force cleared", 2'b00, {frc, pin})
		`CHK("pump1 code kept", 5'h0f, cp1)
		xfer(1'b0, 7'h1d, 8'h1f, q);
		`CHK("offset off", 5'h00, appl)
		xfer(1'b0, 7'h1d, 8'h21, q);
		`CHK("offset one", 9'h009, ddeg)
		xfer(1'b0, 7'h17, 8'h00, q);
		xfer(1'b0, 7'h18, 8'h00, q);
		`CHK("bypass off osc0", 3'b010, {byp, ena, osc})
		xfer(1'b0, 7'h1e, 8'h00, q);
		`CHK("pump2 min", 13'h0c8, cp2_ua)
		$display("test clear and offset done");
	endtask

	task automatic t_unmapped();
		xfer(1'b0, 7'h19, 8'hff, q);
		xfer(1'b1, 7'h19, 8'h00, q);
		`CHK("unmapped read", 8'h00, q)
		xfer(1'b1, 7'h1d, 8'h00, q);
		`CHK("neighbour kept", 8'h21, q)
		$display("test unmapped done");
	endtask

	task automatic t_second_input();
		logic [6:0] cs [3] = '{7'h05, 7'h00, 7'h45};
		logic [6:0] ex [3] = '{7'h05, 7'h01, 7'h41};
		for (int i = 0; i < 3; i++)
		begin
			{input_doubler_select_in, second_loop_predivider_in} = cs[i];
			wt(2);
			`CHK("second loop input", ex[i], {dbl, div})
		end
		$display("test second input done");
	endtask

	// Select indicator, clock-enable freeze, reset in mid-run
	task automatic t_enable_and_reset();
		spi_cs_n_in = 1'b0;
		wt(5);
		`CHK("oe selected", 2'b10, {spi_miso_oe_out, spi_miso_out})
		spi_cs_n_in = 1'b1;
		wt(5);
		`CHK("oe idle", 2'b00, {spi_miso_oe_out, spi_miso_out})
		ce_in = 1'b0;
		xfer(1'b0, 7'h17, 8'h01, q);
		ce_in = 1'b1;
		wt(2);
		`CHK("frozen bypass", 2'b01, {byp, ena})
		rst_n_in = 1'b0;
		wt(3);
		rst_n_in = 1'b1;
		wt(2);
		`CHK("reset force", 2'b11, {frc, pin})
		`CHK("reset pump2", 5'h06, cp2)
		$display("test enable and reset done");
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		{rst_n_in, ce_in, spi_sclk_in, spi_cs_n_in, spi_mosi_in} = 5'b01010;
		{input_doubler_select_in, second_loop_predivider_in} = 7'h00;
		wt(20);
		rst_n_in = 1'b1;
		wt(4);
		t_reset_values();
		t_all_ones();
		t_clear_and_offset();
		t_unmapped();
		t_second_input();
		t_enable_and_reset();
		stop_test();
	end
endmodule // pllcrb_bank_bench
